// [inc/slp_defs.vh]
// Constants for the set-point serial port host controller
`ifndef SLP_DEFS_VH
`define SLP_DEFS_VH

// --------------------------------------------------------------
// Clock and link timing
// --------------------------------------------------------------
`define SLP_CLK_PERIOD_NS   4
`define SLP_T_HALF_CLK_NS   2500
`define SLP_T_STROBE_NS     1000
`define SLP_T_LATCH_NS      2000
`define SLP_TMR_W           12

// --------------------------------------------------------------
// Set-point word
// --------------------------------------------------------------
`define SLP_WORD_W          12
`define SLP_BITCNT_W        4
`define SLP_BITCNT_INIT     4'hC
`define SLP_SETPT_RST       12'h000

// --------------------------------------------------------------
// Register bus and offsets
// --------------------------------------------------------------
`define SLP_ADDR_W          4
`define SLP_DATA_W          16
`define SLP_REG_CTRL        4'h0
`define SLP_REG_SETPT       4'h1
`define SLP_REG_STATUS      4'h2
`define SLP_REG_IRQ_STAT    4'h3
`define SLP_REG_IRQ_MASK    4'h4
`define SLP_REG_LAST        4'h5

// --------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------
`define SLP_CTRL_GO         0
`define SLP_ST_BUSY         0
`define SLP_ST_FAULT        1
`define SLP_ST_PINS_LO      8
`define SLP_IRQ_DONE        0
`define SLP_IRQ_FAULT       1
`define SLP_IRQ_W           2
`define SLP_IRQ_RST         2'h0
`define SLP_MASK_RST        2'h0

// --------------------------------------------------------------
// Port image bits and idle level
// --------------------------------------------------------------
`define SLP_PIN_STROBE      0
`define SLP_PIN_LATCH       1
`define SLP_PIN_DATA        2
`define SLP_PIN_CLK         3
`define SLP_PINS_IDLE       4'hF
`define SLP_FAULT_ACTIVE    1'b1

`endif

// [core/slp_sync.v]
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none

module slp_sync (
  // Clock and reset
  input  wire core_clk_in,
  input  wire srst_in,
  // Level in and out
  input  wire async_in,
  output wire sync_out
);

  reg meta_q;
  reg sync_q;

  // The first stage feeds only the second
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// [core/slp_pace_timer.v]
// Down-counter that paces each step of the serial link
`timescale 1ns/100ps
`default_nettype none
`include "slp_defs.vh"

module slp_pace_timer (
  // Clock and reset
  input  wire                   core_clk_in,
  input  wire                   srst_in,
  // Start and length
  input  wire                   load_in,
  input  wire [`SLP_TMR_W-1:0]  count_in,
  // Expiry pulse
  output wire                   done_out
);

  reg [`SLP_TMR_W-1:0] cnt_q;
  reg                  run_q;
  reg                  done_q;

  // Counts count_in edges after the load, then pulses done for one cycle
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      cnt_q  <= {`SLP_TMR_W{1'b0}};
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else if (load_in)
    begin
      cnt_q  <= count_in;
      run_q  <= 1'b1;
      done_q <= 1'b0;
    end
    else if (run_q && (cnt_q <= {{(`SLP_TMR_W-1){1'b0}}, 1'b1}))
    begin
      run_q  <= 1'b0;
      done_q <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      if (run_q)
        cnt_q <= cnt_q - {{(`SLP_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  assign done_out = done_q;

endmodule

`default_nettype wire

// [core/slp_host_ctrl.v]
// Host controller that programs the load set-point over its four-line serial port
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "slp_defs.vh"

module slp_host_ctrl (
  // Clock and reset
  input  wire                   core_clk_in,
  input  wire                   srst_in,
  // Register port
  input  wire [`SLP_ADDR_W-1:0] addr_in,
  input  wire [`SLP_DATA_W-1:0] wdata_in,
  input  wire                   wr_in,
  input  wire                   rd_in,
  output wire [`SLP_DATA_W-1:0] rdata_out,
  // Interrupt
  output wire                   irq_out,
  // Link pins to the load
  output wire                   word_sel_out,
  output wire                   word_latch_pulse_out,
  output wire                   serial_bit_in_out,
  output wire                   shift_clk_out,
  input  wire                   fault_in
);

  // --------------------------------------------------------------
  // Timing conversion
  // --------------------------------------------------------------

  // Least times round up to whole clock cycles, never below one
  function [`SLP_TMR_W-1:0] ns_to_cyc;
    input integer ns;
    integer c;
    begin
      c = (ns + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS;
      if (c < 1)
        c = 1;
      ns_to_cyc = c[`SLP_TMR_W-1:0];
    end
  endfunction

  localparam [`SLP_TMR_W-1:0] CYC_HALF   = ns_to_cyc(`SLP_T_HALF_CLK_NS);
  localparam [`SLP_TMR_W-1:0] CYC_STROBE = ns_to_cyc(`SLP_T_STROBE_NS);
  localparam [`SLP_TMR_W-1:0] CYC_LATCH  = ns_to_cyc(`SLP_T_LATCH_NS);

  // --------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------
  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_PRE   = 4'h1;
  localparam [3:0] S_SELLO = 4'h2;
  localparam [3:0] S_SETUP = 4'h3;
  localparam [3:0] S_CLKLO = 4'h4;
  localparam [3:0] S_CLKHI = 4'h5;
  localparam [3:0] S_SELHI = 4'h6;
  localparam [3:0] S_LATLO = 4'h7;
  localparam [3:0] S_LATHI = 4'h8;

  reg  [3:0]                state_q;
  reg  [3:0]                state_d;
  reg  [3:0]                pins_q;
  reg  [3:0]                pins_d;
  reg  [`SLP_WORD_W-1:0]    shift_q;
  reg  [`SLP_WORD_W-1:0]    shift_d;
  reg  [`SLP_BITCNT_W-1:0]  bits_q;
  reg  [`SLP_BITCNT_W-1:0]  bits_d;
  reg                       tmr_load;
  reg  [`SLP_TMR_W-1:0]     tmr_count;
  reg                       word_done;
  wire                      tmr_done;

  // Software-visible state
  reg  [`SLP_WORD_W-1:0]    setpt_q;
  reg  [`SLP_WORD_W-1:0]    last_q;
  reg  [`SLP_IRQ_W-1:0]     irq_stat_q;
  reg  [`SLP_IRQ_W-1:0]     irq_stat_d;
  reg  [`SLP_IRQ_W-1:0]     irq_mask_q;
  reg  [`SLP_DATA_W-1:0]    rdata_q;
  reg  [`SLP_DATA_W-1:0]    rdata_d;
  reg                       irq_q;
  reg                       fault_q;
  wire                      fault_sync;
  wire                      fault_lvl;
  wire                      busy;
  wire                      go;

  // --------------------------------------------------------------
  // Helper blocks
  // --------------------------------------------------------------
  slp_pace_timer u_timer (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .load_in     (tmr_load),
    .count_in    (tmr_count),
    .done_out    (tmr_done)
  );

  // The fault pin comes from the isolated load side, so it is resynchronised
  slp_sync u_fault_sync (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .async_in    (fault_in),
    .sync_out    (fault_sync)
  );

  assign fault_lvl = (fault_sync == `SLP_FAULT_ACTIVE);
  assign busy      = (state_q != S_IDLE);
  assign go        = wr_in && (addr_in == `SLP_REG_CTRL) && wdata_in[`SLP_CTRL_GO] && !busy;

  // --------------------------------------------------------------
  // Link sequencer
  // --------------------------------------------------------------

  // Every pin change but the return to idle levels in S_IDLE is paired with a timer load so no gap is shorter than its minimum
  always @*
  begin
    state_d   = state_q;
    pins_d    = pins_q;
    shift_d   = shift_q;
    bits_d    = bits_q;
    tmr_load  = 1'b0;
    tmr_count = CYC_HALF;
    word_done = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        pins_d = `SLP_PINS_IDLE;
        if (go)
        begin
          // Word is captured here so a later write cannot corrupt a transfer
          shift_d   = setpt_q;
          bits_d    = `SLP_BITCNT_INIT;
          tmr_load  = 1'b1;
          tmr_count = CYC_STROBE;
          state_d   = S_PRE;
        end
      end
      S_PRE:
      begin
        if (tmr_done)
        begin
          pins_d[`SLP_PIN_STROBE] = 1'b0;
          tmr_load  = 1'b1;
          tmr_count = CYC_STROBE;
          state_d   = S_SELLO;
        end
      end
      S_SELLO:
      begin
        if (tmr_done)
        begin
          pins_d[`SLP_PIN_DATA] = shift_q[`SLP_WORD_W-1];
          tmr_load = 1'b1;
          state_d  = S_SETUP;
        end
      end
      S_SETUP:
      begin
        if (tmr_done)
        begin
          pins_d[`SLP_PIN_CLK] = 1'b0;
          tmr_load = 1'b1;
          state_d  = S_CLKLO;
        end
      end
      S_CLKLO:
      begin
        if (tmr_done)
        begin
          // The load takes the bit on this rising edge, data held past it
          pins_d[`SLP_PIN_CLK] = 1'b1;
          tmr_load = 1'b1;
          bits_d   = bits_q - {{(`SLP_BITCNT_W-1){1'b0}}, 1'b1};
          shift_d  = {shift_q[`SLP_WORD_W-2:0], 1'b0};
          state_d  = S_CLKHI;
        end
      end
      S_CLKHI:
      begin
        if (tmr_done)
        begin
          tmr_load = 1'b1;
          if (bits_q == {`SLP_BITCNT_W{1'b0}})
          begin
            pins_d[`SLP_PIN_STROBE] = 1'b1;
            tmr_count = CYC_LATCH;
            state_d   = S_SELHI;
          end
          else
          begin
            pins_d[`SLP_PIN_DATA] = shift_q[`SLP_WORD_W-1];
            state_d = S_SETUP;
          end
        end
      end
      S_SELHI:
      begin
        if (tmr_done)
        begin
          pins_d[`SLP_PIN_LATCH] = 1'b0;
          tmr_load  = 1'b1;
          tmr_count = CYC_LATCH;
          state_d   = S_LATLO;
        end
      end
      S_LATLO:
      begin
        if (tmr_done)
        begin
          pins_d[`SLP_PIN_LATCH] = 1'b1;
          tmr_load  = 1'b1;
          tmr_count = CYC_LATCH;
          state_d   = S_LATHI;
        end
      end
      S_LATHI:
      begin
        // Recovery gap so a word started straight after cannot drop the strobe too soon
        if (tmr_done)
        begin
          word_done = 1'b1;
          state_d   = S_IDLE;
        end
      end
      default:
      begin
        pins_d  = `SLP_PINS_IDLE;
        state_d = S_IDLE;
      end
    endcase
  end

  // Sequencer registers; the idle level is all high from reset
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      state_q <= S_IDLE;
      pins_q  <= `SLP_PINS_IDLE;
      shift_q <= `SLP_SETPT_RST;
      bits_q  <= {`SLP_BITCNT_W{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      pins_q  <= pins_d;
      shift_q <= shift_d;
      bits_q  <= bits_d;
    end
  end

  // Pins come straight from the port image register
  assign word_sel_out         = pins_q[`SLP_PIN_STROBE];
  assign word_latch_pulse_out = pins_q[`SLP_PIN_LATCH];
  assign serial_bit_in_out    = pins_q[`SLP_PIN_DATA];
  assign shift_clk_out        = pins_q[`SLP_PIN_CLK];

  // --------------------------------------------------------------
  // Registers and interrupt
  // --------------------------------------------------------------

  // Hardware set wins over a write-one clear in the same cycle
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (wr_in && (addr_in == `SLP_REG_IRQ_STAT))
      irq_stat_d = irq_stat_q & ~wdata_in[`SLP_IRQ_W-1:0];
    if (word_done)
      irq_stat_d[`SLP_IRQ_DONE] = 1'b1;
    if (fault_lvl && !fault_q)
      irq_stat_d[`SLP_IRQ_FAULT] = 1'b1;
  end

  // Read mux; unmapped offsets read as zero
  always @*
  begin
    rdata_d = {`SLP_DATA_W{1'b0}};
    if (rd_in)
    begin
      case (addr_in)
        `SLP_REG_CTRL:     rdata_d[`SLP_CTRL_GO] = busy;
        `SLP_REG_SETPT:    rdata_d[`SLP_WORD_W-1:0] = setpt_q;
        `SLP_REG_STATUS:
        begin
          rdata_d[`SLP_ST_BUSY]  = busy;
          rdata_d[`SLP_ST_FAULT] = fault_lvl;
          rdata_d[`SLP_ST_PINS_LO+3:`SLP_ST_PINS_LO] = pins_q;
        end
        `SLP_REG_IRQ_STAT: rdata_d[`SLP_IRQ_W-1:0] = irq_stat_q;
        `SLP_REG_IRQ_MASK: rdata_d[`SLP_IRQ_W-1:0] = irq_mask_q;
        `SLP_REG_LAST:     rdata_d[`SLP_WORD_W-1:0] = last_q;
        default:           rdata_d = {`SLP_DATA_W{1'b0}};
      endcase
    end
  end

  // Set-point may be rewritten while busy; the running word was captured at start
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      setpt_q    <= `SLP_SETPT_RST;
      last_q     <= `SLP_SETPT_RST;
      irq_stat_q <= `SLP_IRQ_RST;
      irq_mask_q <= `SLP_MASK_RST;
      rdata_q    <= {`SLP_DATA_W{1'b0}};
      irq_q      <= 1'b0;
      fault_q    <= 1'b0;
    end
    else
    begin
      if (wr_in && (addr_in == `SLP_REG_SETPT))
        setpt_q <= wdata_in[`SLP_WORD_W-1:0];
      if (wr_in && (addr_in == `SLP_REG_IRQ_MASK))
        irq_mask_q <= wdata_in[`SLP_IRQ_W-1:0];
      if (go)
        last_q <= setpt_q;
      irq_stat_q <= irq_stat_d;
      rdata_q    <= rdata_d;
      irq_q      <= |(irq_stat_d & irq_mask_q);
      fault_q    <= fault_lvl;
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out   = irq_q;

endmodule

`default_nettype wire

// [test/slp_host_ctrl_properties.sv]
// Pin timing checks for the set-point port host controller
`timescale 1ns/100ps
`default_nettype none
`include "slp_defs.vh"

module slp_host_ctrl_properties (
  // Clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   srst_in,
  // Register port
  input  wire logic                   rd_in,
  input  wire logic [`SLP_DATA_W-1:0] rdata_out,
  // Link pins
  input  wire logic                   word_sel_out,
  input  wire logic                   word_latch_pulse_out,
  input  wire logic                   serial_bit_in_out,
  input  wire logic                   shift_clk_out
);
  logic [9:0] clk_lo_q;
  logic [9:0] lat_lo_q;
  logic [3:0] rises_q;
  logic       sclk_q;

  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  // Counters instead of long repetitions, which tools unroll badly
  always @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      clk_lo_q <= 10'h000;
      lat_lo_q <= 10'h000;
      rises_q  <= 4'h0;
      sclk_q   <= 1'b1;
    end
    else
    begin
      clk_lo_q <= shift_clk_out ? 10'h000 : clk_lo_q + 10'h001;
      lat_lo_q <= word_latch_pulse_out ? 10'h000 : lat_lo_q + 10'h001;
      rises_q  <= word_sel_out ? 4'h0 : rises_q + {3'h0, shift_clk_out & ~sclk_q};
      sclk_q   <= shift_clk_out;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  a_pre_all_high: assert property (
    $fell(word_sel_out) |-> $past(shift_clk_out) && $past(word_latch_pulse_out) && $past(word_sel_out, 250))
    else $error("Strobe fell without idle-high setup");
  a_clk_gated: assert property (
    $fell(shift_clk_out) |-> !word_sel_out && word_latch_pulse_out)
    else $error("Shift clock pulsed outside a word");
  a_data_stable: assert property (
    !shift_clk_out |-> $stable(serial_bit_in_out))
    else $error("Serial data moved while shift clock low");
  a_clk_low_width: assert property (
    $rose(shift_clk_out) |-> clk_lo_q == 10'd626)
    else $error("Shift clock low phase wrong length");
  a_clk_high_span: assert property (
    $fell(shift_clk_out) |-> $past(shift_clk_out, 300) && $past(shift_clk_out, 625))
    else $error("Shift clock high phase too short");
  a_twelve_bits: assert property (
    $rose(word_sel_out) |-> rises_q == 4'd12)
    else $error("Word did not carry twelve clock pulses");
  a_latch_after_strobe: assert property (
    $fell(word_latch_pulse_out) |-> word_sel_out && shift_clk_out && $past(word_sel_out, 500))
    else $error("Latch pulse not after strobe rise gap");
  a_latch_width: assert property (
    $rose(word_latch_pulse_out) |-> lat_lo_q == 10'd501)
    else $error("Latch low pulse wrong width");
  a_rdata_idle: assert property (
    !$past(rd_in) |-> rdata_out == 16'h0000)
    else $error("Read data not zero outside read answer");
endmodule

bind slp_host_ctrl slp_host_ctrl_properties u_props (
  .core_clk_in          (core_clk_in),
  .srst_in              (srst_in),
  .rd_in                (rd_in),
  .rdata_out            (rdata_out),
  .word_sel_out         (word_sel_out),
  .word_latch_pulse_out (word_latch_pulse_out),
  .serial_bit_in_out    (serial_bit_in_out),
  .shift_clk_out        (shift_clk_out)
);
`default_nettype wire

// [test/slp_load_model.sv]
// Behavioural model of the electronic load serial set-point port
`timescale 1ns/100ps
`default_nettype none

module slp_load_model (
  // Link pins from the host
  input  wire logic        word_sel_in,
  input  wire logic        word_latch_pulse_in,
  input  wire logic        serial_bit_in,
  input  wire logic        shift_clk_in,
  // Fault condition chosen by the bench
  input  wire logic        fault_cond_in,
  // Fault pin and converter view
  output logic             fault_out,
  output logic [11:0]      setpt_out,
  output logic [20:0]      current_ua_out
);
  logic [11:0] shift_q = 12'h000;
  logic [11:0] dac_q   = 12'h000;

  // Shift on clock rise only while the strobe is low; first bit ends at the top
  always @(posedge shift_clk_in)
    if (word_sel_in === 1'b0)
      shift_q <= {shift_q[10:0], serial_bit_in};

  // Converter keeps its old word until a latch rise with the strobe high
  always @(posedge word_latch_pulse_in)
    if (word_sel_in === 1'b1)
      dac_q <= shift_q;

  // Power-up word assumed zero; current in microamperes, 500 per code step
  assign setpt_out      = dac_q;
  assign current_ua_out = {9'h000, dac_q} * 21'd500;
  assign fault_out      = fault_cond_in;
endmodule
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the set-point port host controller
`timescale 1ns/100ps
`default_nettype none
`include "slp_defs.vh"

module testbench;
  logic        core_clk_in = 1'b0;
  logic        srst_in     = 1'b1;
  logic        wr_in       = 1'b0;
  logic        rd_in       = 1'b0;
  logic        fault_cond  = 1'b0;
  logic [3:0]  addr_in     = 4'h0;
  logic [15:0] wdata_in    = 16'h0000;
  logic [15:0] r;
  wire  [15:0] rdata_out;
  wire         irq_out;
  wire         ws;
  wire         wl;
  wire         sd;
  wire         sc;
  wire         flt;
  wire  [11:0] dac;
  wire  [20:0] cur;
  int          fails       = 0;
  int          checks_done = 0;

  // ------------------------------------------------------------
  // Design and load model
  // ------------------------------------------------------------
  slp_host_ctrl u_slp_host_ctrl (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .word_sel_out(ws),
    .word_latch_pulse_out(wl), .serial_bit_in_out(sd), .shift_clk_out(sc), .fault_in(flt));
  slp_load_model u_slp_load_model (
    .word_sel_in(ws), .word_latch_pulse_in(wl), .serial_bit_in(sd), .shift_clk_in(sc),
    .fault_cond_in(fault_cond), .fault_out(flt), .setpt_out(dac), .current_ua_out(cur));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 r = rdata_out;
    chk(n, {16'h0000, e}, {16'h0000, r});
  endtask
  // Bounded wait; one word takes about 24.5k cycles from its start
  task automatic wait_irq;
    int i;
    #1;
    for (i = 0; i < 30000 && irq_out !== 1'b1; i++)
      #4;
    chk("irq_out", 32'h1, {31'h0, irq_out});
  endtask
  task automatic report_and_stop;
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and tests
  // ------------------------------------------------------------
  initial
    forever #2 core_clk_in = ~core_clk_in;

  initial
  begin
    #280000;
    fails++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge core_clk_in);
    srst_in <= 1'b0;
    rdc("status", `SLP_REG_STATUS, 16'h0F00);
    rdc("unmapped", 4'h9, 16'h0000);
    wr(`SLP_REG_IRQ_MASK, 16'h0003);
    wr(`SLP_REG_SETPT, 16'hFA53);
    rdc("setpt", `SLP_REG_SETPT, 16'h0A53);
    wr(`SLP_REG_CTRL, 16'h0001);
    wr(`SLP_REG_SETPT, 16'h0123);
    wr(`SLP_REG_CTRL, 16'h0001);
    rdc("busy", `SLP_REG_CTRL, 16'h0001);
    wait_irq();
    chk("dac", 32'hA53, {20'h0, dac});
    chk("current", 32'd1321500, {11'h0, cur});
    rdc("last", `SLP_REG_LAST, 16'h0A53);
    rdc("irq_stat", `SLP_REG_IRQ_STAT, 16'h0001);
    wr(`SLP_REG_IRQ_STAT, 16'h0001);
    rdc("irq_clr", `SLP_REG_IRQ_STAT, 16'h0000);
    chk("irq_low", 32'h0, {31'h0, irq_out});
    // Second word: old value must stay on the converter while shifting
    wr(`SLP_REG_CTRL, 16'h0001);
    repeat (3000) @(posedge core_clk_in);
    chk("dac_held", 32'hA53, {20'h0, dac});
    wait_irq();
    chk("dac2", 32'h123, {20'h0, dac});
    chk("current2", 32'd145500, {11'h0, cur});
    wr(`SLP_REG_IRQ_STAT, 16'h0001);
    // Fault raised, reported, masked and cleared
    @(posedge core_clk_in);
    fault_cond <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    rdc("fault_st", `SLP_REG_STATUS, 16'h0F02);
    rdc("fault_irq", `SLP_REG_IRQ_STAT, 16'h0002);
    chk("irq_fault", 32'h1, {31'h0, irq_out});
    wr(`SLP_REG_IRQ_MASK, 16'h0001);
    repeat (2) @(posedge core_clk_in);
    #1 chk("irq_masked", 32'h0, {31'h0, irq_out});
    wr(`SLP_REG_IRQ_STAT, 16'h0002);
    fault_cond <= 1'b0;
    rdc("fault_clr", `SLP_REG_IRQ_STAT, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
